// ===== dv/rbt_ctrl_checker.sv
// Checker of bus timing and output relations of rbt_ctrl.
// Assumes a bind to rbt_ctrl and a single hclk domain.
`timescale 1ns/100ps
`include "rbt_consts.vh"
module rbt_ctrl_checker #(
  parameter TICK_CYCLES = 20
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        hresp,
  input wire        run_state,
  input wire [15:0] ramp_out,
  input wire [15:0] torque_demand,
  input wire [15:0] freq_ref_out,
  input wire [15:0] reg_if_demand,
  input wire [15:0] reg_iq_demand,
  input wire [7:0]  volt_scale,
  input wire        ramp_bypass
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  // Phase of output changes; first change after reset only arms it
  wire [47:0]  ov  = {ramp_out, torque_demand, freq_ref_out};
  logic [47:0] oq;
  logic        seen;
  int unsigned ph;
  int unsigned bc;
  wire         chg = ov != oq;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oq <= '0;
      seen <= 1'b0;
      ph <= 0;
      bc <= 0;
    end else begin
      oq <= ov;
      bc <= (!run_state && ramp_bypass) ? bc + 1 : 0;
      if (chg) begin
        seen <= 1'b1;
        ph <= 1;
      end else begin
        ph <= (ph == TICK_CYCLES - 1) ? 0 : ph + 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd |=> s_wait;
  endproperty
  property p_wr_zero;
    hsel && htrans[1] && hready && hwrite |=> hreadyout;
  endproperty
  property p_okay;
    !hresp;
  endproperty
  property p_hold;
    $changed(hrdata) |-> hreadyout && !$past(hreadyout);
  endproperty
  property p_tick;
    chg && seen |-> ph == 0;
  endproperty
  property p_vscale;
    volt_scale == `RBT_VSCALE_NORM || volt_scale == `RBT_VSCALE_BOOST;
  endproperty
  property p_route;
    !(reg_if_demand != 16'h0000 && reg_iq_demand != 16'h0000);
  endproperty
  property p_bypass;
    bc <= 3 * TICK_CYCLES;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  a_wr_zero: assert property (p_wr_zero)
    else $error("write inserted a wait state");
  a_okay: assert property (p_okay)
    else $error("response not OKAY");
  a_hold: assert property (p_hold)
    else $error("read data moved outside a read");
  a_tick: assert property (p_tick)
    else $error("output changed off the tick");
  a_vscale: assert property (p_vscale)
    else $error("voltage scale out of range");
  a_route: assert property (p_route)
    else $error("regulator current on both paths");
  a_bypass: assert property (p_bypass)
    else $error("ramp bypass outlived run state");
endmodule // rbt_ctrl_checker

bind rbt_ctrl rbt_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
  .hresp, .run_state, .ramp_out, .torque_demand, .freq_ref_out,
  .reg_if_demand, .reg_iq_demand, .volt_scale, .ramp_bypass
);

// ===== dv/rbt_ctrl_tb.sv
// Self-checking bench of rbt_ctrl over AHB-Lite and drive ports.
// Assumes a short control tick; expectations come from the bench.
`timescale 1ns/100ps
`include "rbt_consts.vh"
module rbt_ctrl_tb;
  localparam int T = 20;
  logic        hclk = 0;
  logic        hresetn = 0;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [15:0] speed_ref = 0;
  logic [15:0] speed_loop_out = 0;
  logic [15:0] torque_ref_in = 0;
  logic [15:0] link_voltage = 16'h0200;
  logic        ilim_active = 0;
  logic        run_state = 0;
  logic        force_en = 0;
  logic [15:0] force_val = 0;
  wire         hreadyout, hresp, coast_req, overspeed_trip, ramp_bypass;
  wire  [31:0] hrdata;
  wire  [15:0] speed_meas, current_fb, ramp_out, torque_demand;
  wire  [15:0] freq_ref_out, reg_if_demand, reg_iq_demand;
  wire  [7:0]  volt_scale;
  int          num_errors = 0, check_count = 0, cyc = 0;
  int          i, ex, tm, sl, tr, of;
  logic [31:0] q, v;
  logic [15:0] r0;
  logic [31:0] rst [9] = '{`RBT_RST_CTRL_NS, `RBT_RST_ACCEL,
    `RBT_RST_DECEL, `RBT_RST_THRESH, `RBT_RST_NOMINAL, `RBT_RST_JERK,
    `RBT_RST_TOFFSET, `RBT_RST_TOPFREQ, `RBT_RST_OVSPEED};
  always #5 hclk = ~hclk;
  rbt_ctrl #(.TICK_CYCLES(T), .STALL_TICKS(8)) dut_u (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .speed_ref,
    .speed_meas, .speed_loop_out, .torque_ref_in, .current_fb,
    .link_voltage, .run_state, .drive_disabled(1'b0), .ilim_active,
    .ramp_out, .torque_demand, .freq_ref_out, .reg_if_demand,
    .reg_iq_demand, .volt_scale, .coast_req, .overspeed_trip, .ramp_bypass);
  rbt_drive_model mdl_u (.hclk, .hresetn, .freq_ref_out, .torque_demand,
    .force_en, .force_val, .speed_meas, .current_fb);
  ////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tk(input int n);
    repeat (n * T) @(posedge hclk);
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Hang guard sized well above the whole sequence
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h50467C52));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 9; i++) begin
      bus(8'(4 * i), 1'b0, 32'h0);
      chk(q, rst[i]);
    end
    for (i = 1; i < 9; i++) begin
      v = $urandom;
      bus(8'(4 * i), 1'b1, v);
      bus(8'(4 * i), 1'b0, 32'h0);
      chk(q, v & 32'h0000FFFF);
      bus(8'(4 * i), 1'b1, rst[i]);
    end
    bus(8'h2C, 1'b1, v);
    bus(8'h2C, 1'b0, 32'h0);
    chk(q, 32'h0);
    run_state <= 1'b1;
    for (i = 0; i < 4; i++) begin
      tm = (i == 3) ? 4 : i;
      sl = $urandom_range(2000) - 1000;
      tr = $urandom_range(1000) + 1;
      of = (i == 1) ? $urandom_range(500) : 0;
      bus(`RBT_OFF_TOFFSET, 1'b1, of);
      bus(`RBT_OFF_CTRL, 1'b1, 32'h7C0 | (tm << 3));
      speed_loop_out <= sl[15:0];
      torque_ref_in <= tr[15:0];
      tk(3);
      case (tm)
        0: ex = sl;
        1: ex = tr + of;
        2: ex = (sl < 0) ? 0 : ((sl > tr) ? tr : sl);
        default: ex = sl + tr;
      endcase
      chk(torque_demand, ex[15:0]);
      if (tm == 1) begin
        chk(ramp_bypass, 32'h1);
        force_en <= 1'b1;
        force_val <= 16'h7800;
        tk(3);
        chk(overspeed_trip, 32'h1);
        force_en <= 1'b0;
        // Speed back at rest before the stop preload samples it
        tk(1);
        run_state <= 1'b0;
        tk(4);
        chk(overspeed_trip, 32'h1);
        chk(ramp_bypass, 32'h0);
        run_state <= 1'b1;
      end
    end
    bus(`RBT_OFF_CTRL, 1'b1, 32'h404);
    bus(`RBT_OFF_ACCEL, 1'b1, 32'h40);
    bus(`RBT_OFF_JERK, 1'b1, 32'h10);
    speed_ref <= 16'h4000;
    tk(2);
    r0 = ramp_out;
    tk(1);
    // Early S-curve step stays within two jerk increments
    chk(32'(16'(ramp_out - r0) <= 16'h0020), 32'h1);
    tk(5);
    r0 = ramp_out;
    tk(1);
    chk(16'(ramp_out - r0), 32'h40);
    bus(`RBT_OFF_CTRL, 1'b1, 32'h400);
    ilim_active <= 1'b1;
    tk(2);
    r0 = ramp_out;
    tk(1);
    chk(16'(ramp_out - r0), 32'h0);
    ilim_active <= 1'b0;
    speed_ref <= 16'h0000;
    tk(2);
    r0 = ramp_out;
    tk(1);
    chk(16'(r0 - ramp_out), `RBT_RST_DECEL);
    chk(volt_scale, `RBT_VSCALE_NORM);
    bus(`RBT_OFF_CTRL, 1'b1, 32'h402);
    tk(2);
    chk(volt_scale, `RBT_VSCALE_BOOST);
    r0 = ramp_out;
    tk(1);
    chk(16'(r0 - ramp_out), `RBT_RST_DECEL);
    bus(`RBT_OFF_CTRL, 1'b1, 32'h401);
    link_voltage <= `RBT_RST_THRESH + 16'h0040;
    // Regulator engages on one tick and shows on the next
    tk(3);
    chk(reg_if_demand, 16'h0040 >> `RBT_REG_SHIFT);
    chk(reg_iq_demand, 32'h0);
    bus(`RBT_OFF_THRESH, 1'b1, 32'h100);
    tk(2);
    chk(coast_req, 32'h1);
    bus(`RBT_OFF_TOPFREQ, 1'b1, 32'h20);
    bus(`RBT_OFF_CTRL, 1'b1, 32'h408);
    torque_ref_in <= 16'h1000;
    // Slow reference sampling needs up to 16 ticks
    tk(18);
    chk(freq_ref_out, 32'h20);
    print_verdict();
  end
endmodule // rbt_ctrl_tb

// ===== dv/rbt_drive_model.sv
// Motor and current controllers seen by rbt_ctrl.
// Assumes hclk domain; the bench may override the measured speed.
`timescale 1ns/100ps
module rbt_drive_model (
  input wire         hclk,
  input wire         hresetn,
  input wire  [15:0] freq_ref_out,
  input wire  [15:0] torque_demand,
  input wire         force_en,
  input wire  [15:0] force_val,
  output logic [15:0] speed_meas,
  output logic [15:0] current_fb
);
  // Ideal motor: speed follows the frequency demand one hclk later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_meas <= 16'h0000;
      current_fb <= 16'h0000;
    end else begin
      speed_meas <= force_en ? force_val : freq_ref_out;
      current_fb <= {torque_demand[15], torque_demand[15:1]};
    end
  end
endmodule // rbt_drive_model

// ===== rtl/rbt_consts.vh
// Constants of the ramp, braking and torque-mode controller.
// Assumes a 100 MHz hclk; included by rbt_ctrl.v and by the dv checker and bench.
`ifndef RBT_CONSTS_VH
`define RBT_CONSTS_VH

// Register byte offsets
`define RBT_OFF_CTRL     8'h00
`define RBT_OFF_ACCEL    8'h04
`define RBT_OFF_DECEL    8'h08
`define RBT_OFF_THRESH   8'h0C
`define RBT_OFF_NOMINAL  8'h10
`define RBT_OFF_JERK     8'h14
`define RBT_OFF_TOFFSET  8'h18
`define RBT_OFF_TOPFREQ  8'h1C
`define RBT_OFF_OVSPEED  8'h20
`define RBT_OFF_STATUS   8'h24
`define RBT_OFF_DEMAND   8'h28

// Control register fields
`define RBT_CTRL_RMODE_LO  0
`define RBT_CTRL_RMODE_HI  1
`define RBT_CTRL_SCURVE    2
`define RBT_CTRL_TMODE_LO  3
`define RBT_CTRL_TMODE_HI  5
`define RBT_CTRL_CLOSED    6
`define RBT_CTRL_OFF_EN    7
`define RBT_CTRL_SRC_AIN23 8
`define RBT_CTRL_AIN_VZERO 9
`define RBT_CTRL_STOP_LO   10
`define RBT_CTRL_STOP_HI   11

// Status register fields (low half carries the ramp output)
`define RBT_ST_REG_ACT   16
`define RBT_ST_COAST     17
`define RBT_ST_TRIP      18
`define RBT_ST_STALL     19
`define RBT_ST_DECEL     20
`define RBT_ST_BYPASS    21

// Reset values
`define RBT_RST_CTRL     12'h404
`define RBT_RST_CTRL_NS  12'h400
`define RBT_RST_ACCEL    16'h0010
`define RBT_RST_DECEL    16'h0010
`define RBT_RST_THRESH   16'h02EE
`define RBT_RST_NOMINAL  16'h0230
`define RBT_RST_JERK     16'h0001
`define RBT_RST_TOFFSET  16'h0000
`define RBT_RST_TOPFREQ  16'h7FFF
`define RBT_RST_OVSPEED  16'h7000

// Modes
`define RBT_RMODE_FAST   2'h0
`define RBT_RMODE_STD    2'h1
`define RBT_RMODE_BOOST  2'h2
`define RBT_STOP_COAST   2'h0
`define RBT_STOP_RAMP    2'h1
`define RBT_STOP_NORAMP  2'h2
`define RBT_VSCALE_NORM  8'h64
`define RBT_VSCALE_BOOST 8'h78

// Timing
`define RBT_CLK_MHZ      100
`define RBT_TICK_US      250
`define RBT_TICK_CYCLES  (`RBT_TICK_US * `RBT_CLK_MHZ)
`define RBT_TREF_SLOW_US 4000
`define RBT_TREF_DIV     (`RBT_TREF_SLOW_US / `RBT_TICK_US)
`define RBT_STALL_S      10
`define RBT_STALL_TICKS  (`RBT_STALL_S * 1000000 / `RBT_TICK_US)

// Loop gains as right shifts
`define RBT_REG_SHIFT    2
`define RBT_PI_KP_SHIFT  2
`define RBT_PI_KI_SHIFT  4

`endif

// ===== rtl/rbt_ctrl.v
// Speed ramp, deceleration braking, S-curve and torque-mode selection.
// Assumes all drive-side inputs come from logic on hclk; registers
// reached over AHB-Lite.
// What this block does
// - Ramp mode 0 decelerates at the set rate, no link regulation.
// - Ramp mode only touches deceleration; acceleration uses accel rate except while ilim_active holds the ramp.
// - While stopping, speed not falling for 10 s forces reference to zero.
// - Modes 1/2: link voltage at threshold engages current regulator.
// - Regulator drops out once deceleration reaches the programmed rate.
// - Regulator current goes to frequency or torque current controller.
// - Threshold below nominal link level: motor coasts to rest.
// - Mode 2 as mode 1 plus 20% motor voltage boost when decelerating.
// - S-curve enable bit, on at 1, off at 0, reset off.
// - S-curve suppressed during bus-regulated deceleration.
// - Accelerating after regulated decel clears S-curve acceleration state.
// - Jerk setting bounds change of acceleration and deceleration.
// - Curve time is rate over jerk; ramp lengthened by T overall.
// - Torque reference sampled every 4 ms, 250 us on fast analog path.
// - Open loop mode 1: current PI gives clamped frequency reference.
// - Closed loop torque modes 1-3 bypass ramps while running.
// - Leaving run, not disabled: stop mode; ramp stop from torque bypass preloads speed.
// - Torque mode 0 passes speed loop output as torque demand.
// - Mode 1: reference plus optional offset; overspeed trips in closed loop.
// - Mode 2 clamps speed loop output between zero and torque reference.
// - Mode 4 adds torque feed-forward to speed loop output.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "rbt_consts.vh"

module rbt_ctrl #(
  parameter TICK_CYCLES = `RBT_TICK_CYCLES,
  parameter STALL_TICKS = `RBT_STALL_TICKS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire [15:0] speed_ref,
  input  wire [15:0] speed_meas,
  input  wire [15:0] speed_loop_out,
  input  wire [15:0] torque_ref_in,
  input  wire [15:0] current_fb,
  input  wire [15:0] link_voltage,
  input  wire        run_state,
  input  wire        drive_disabled,
  input  wire        ilim_active,
  output reg  [15:0] ramp_out,
  output reg  [15:0] torque_demand,
  output reg  [15:0] freq_ref_out,
  output reg  [15:0] reg_if_demand,
  output reg  [15:0] reg_iq_demand,
  output reg  [7:0]  volt_scale,
  output reg         coast_req,
  output reg         overspeed_trip,
  output reg         ramp_bypass
);

  function [15:0] sat16;
    input signed [19:0] v;
    begin
      if (v > 20'sh07FFF)
        sat16 = 16'h7FFF;
      else if (v < -20'sh08000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  function [15:0] absv;
    input [15:0] v;
    begin
      absv = v[15] ? (16'h0000 - v) : v;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero-wait writes, one wait state on reads

  reg  [11:0] ctrl_reg;
  reg  [15:0] accel_reg, decel_reg, thresh_reg, nominal_reg;
  reg  [15:0] jerk_reg, toff_reg, topf_reg, ovspd_reg;
  reg  [7:0]  waddr_reg;
  reg         wpend_reg;
  reg  [7:0]  raddr_reg;
  reg         rpend_reg;
  reg         reg_act_reg, stall_zero_reg, decel_reg_q;
  wire        trip_clr;
  reg  [31:0] rd_mux;

  wire acc_phase = hsel && htrans[1] && hready;

  always @* begin
    case (raddr_reg)
      `RBT_OFF_CTRL:    rd_mux = {20'h00000, ctrl_reg};
      `RBT_OFF_ACCEL:   rd_mux = {16'h0000, accel_reg};
      `RBT_OFF_DECEL:   rd_mux = {16'h0000, decel_reg};
      `RBT_OFF_THRESH:  rd_mux = {16'h0000, thresh_reg};
      `RBT_OFF_NOMINAL: rd_mux = {16'h0000, nominal_reg};
      `RBT_OFF_JERK:    rd_mux = {16'h0000, jerk_reg};
      `RBT_OFF_TOFFSET: rd_mux = {16'h0000, toff_reg};
      `RBT_OFF_TOPFREQ: rd_mux = {16'h0000, topf_reg};
      `RBT_OFF_OVSPEED: rd_mux = {16'h0000, ovspd_reg};
      `RBT_OFF_STATUS:  rd_mux = {10'h000, ramp_bypass, decel_reg_q,
                                  stall_zero_reg, overspeed_trip,
                                  coast_req, reg_act_reg, ramp_out};
      `RBT_OFF_DEMAND:  rd_mux = {freq_ref_out, torque_demand};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      rpend_reg <= 1'b0;
      raddr_reg <= 8'h00;
    end else begin
      wpend_reg <= acc_phase && hwrite;
      if (acc_phase)
        waddr_reg <= {haddr[7:2], 2'b00};
      if (acc_phase && !hwrite) begin
        raddr_reg <= {haddr[7:2], 2'b00};
        rpend_reg <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rpend_reg) begin
        // Late capture so a write just before is seen
        hrdata    <= rd_mux;
        rpend_reg <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  assign trip_clr = wpend_reg && (waddr_reg == `RBT_OFF_STATUS)
                    && hwdata[`RBT_ST_TRIP];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg    <= `RBT_RST_CTRL_NS;
      accel_reg   <= `RBT_RST_ACCEL;
      decel_reg   <= `RBT_RST_DECEL;
      thresh_reg  <= `RBT_RST_THRESH;
      nominal_reg <= `RBT_RST_NOMINAL;
      jerk_reg    <= `RBT_RST_JERK;
      toff_reg    <= `RBT_RST_TOFFSET;
      topf_reg    <= `RBT_RST_TOPFREQ;
      ovspd_reg   <= `RBT_RST_OVSPEED;
    end else if (wpend_reg) begin
      case (waddr_reg)
        `RBT_OFF_CTRL:    ctrl_reg    <= hwdata[11:0];
        `RBT_OFF_ACCEL:   accel_reg   <= hwdata[15:0];
        `RBT_OFF_DECEL:   decel_reg   <= hwdata[15:0];
        `RBT_OFF_THRESH:  thresh_reg  <= hwdata[15:0];
        `RBT_OFF_NOMINAL: nominal_reg <= hwdata[15:0];
        `RBT_OFF_JERK:    jerk_reg    <= hwdata[15:0];
        `RBT_OFF_TOFFSET: toff_reg    <= hwdata[15:0];
        `RBT_OFF_TOPFREQ: topf_reg    <= hwdata[15:0];
        `RBT_OFF_OVSPEED: ovspd_reg   <= hwdata[15:0];
        default:          ctrl_reg    <= ctrl_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control tick divider

  reg [31:0] tick_cnt;
  reg        tick;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ramp and braking decisions

  wire [1:0] rmode  = ctrl_reg[`RBT_CTRL_RMODE_HI:`RBT_CTRL_RMODE_LO];
  wire [2:0] tmode  = ctrl_reg[`RBT_CTRL_TMODE_HI:`RBT_CTRL_TMODE_LO];
  wire [1:0] smode  = ctrl_reg[`RBT_CTRL_STOP_HI:`RBT_CTRL_STOP_LO];
  wire       closed = ctrl_reg[`RBT_CTRL_CLOSED];
  wire       s_en   = ctrl_reg[`RBT_CTRL_SCURVE];

  reg  [15:0] ramp_reg;
  reg  signed [17:0] acc_reg;
  reg         was_reg_q, run_q;
  wire        stopping = !run_state && !drive_disabled;
  wire        tq_bypass = closed && (tmode >= 3'h1) && (tmode <= 3'h3);
  wire [15:0] target = (stopping || stall_zero_reg) ? 16'h0000 : speed_ref;
  wire        decel = (ramp_reg != 16'h0000) && ((target == 16'h0000) ||
                      (target[15] != ramp_reg[15]) ||
                      (absv(target) < absv(ramp_reg)));
  wire        regulated = decel && (rmode != `RBT_RMODE_FAST);
  wire signed [17:0] diff = $signed({target[15], target[15], target})
                          - $signed({ramp_reg[15], ramp_reg[15], ramp_reg});
  wire signed [17:0] verr = $signed({2'b00, link_voltage})
                          - $signed({2'b00, thresh_reg});
  wire [15:0] reg_cur = verr[17] ? 16'h0000 :
                        sat16({2'b00, verr} >>> `RBT_REG_SHIFT);
  wire [15:0] reg_step = (reg_cur >= decel_reg) ? 16'h0000
                         : decel_reg - reg_cur;
  wire [15:0] base_step = decel ? decel_reg : accel_reg;
  wire [15:0] step = ilim_active ? 16'h0000
                     : (reg_act_reg ? reg_step : base_step);
  wire        coast_c = (regulated && (thresh_reg < nominal_reg)) ||
                        (stopping && smode == `RBT_STOP_COAST);
  wire        s_act = s_en && !regulated && (jerk_reg != 16'h0000);
  wire signed [17:0] sstep = $signed({2'b00, step});
  wire signed [17:0] want = diff[17] ? -sstep : sstep;
  wire [35:0] acc_sq = $signed(acc_reg) * $signed(acc_reg);
  wire [35:0] brake_d = {2'b00, jerk_reg, 1'b0} * (diff[17] ?
                        (18'h00000 - diff) : diff);
  // Start easing in early enough to land on the target with acc at zero
  wire signed [17:0] want_s = (acc_sq >= brake_d) ? 18'sh00000 : want;
  wire signed [17:0] jstep = $signed({2'b00, jerk_reg});
  wire signed [17:0] acc_n = (want_s > acc_reg + jstep) ? acc_reg + jstep :
                             (want_s < acc_reg - jstep) ? acc_reg - jstep :
                             want_s;
  wire signed [17:0] mv = s_act ? acc_n : ((diff > sstep) ? sstep :
                          (diff < -sstep) ? -sstep : diff);
  wire        overshoot = diff[17] ? (mv < diff) : (mv > diff);
  wire signed [17:0] ramp_n = overshoot ? $signed({target[15],
                          target[15], target}) : $signed({ramp_reg[15],
                          ramp_reg[15], ramp_reg}) + mv;

  //////////////////////////////////////////////////////////////////////////
  // Ramp state, regulator and stall supervision, once per tick

  reg [31:0] stall_cnt;
  reg [15:0] prev_abs;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_reg       <= 16'h0000;
      acc_reg        <= 18'sh00000;
      reg_act_reg    <= 1'b0;
      was_reg_q      <= 1'b0;
      run_q          <= 1'b0;
      stall_cnt      <= 32'h00000000;
      stall_zero_reg <= 1'b0;
      prev_abs       <= 16'h0000;
      decel_reg_q    <= 1'b0;
    end else if (tick) begin
      run_q       <= run_state;
      decel_reg_q <= decel;
      prev_abs    <= absv(speed_meas);
      if (!regulated)
        reg_act_reg <= 1'b0;
      else if (reg_act_reg && reg_step >= decel_reg)
        reg_act_reg <= 1'b0;
      else if (link_voltage >= thresh_reg)
        reg_act_reg <= 1'b1;
      if (reg_act_reg)
        was_reg_q <= 1'b1;
      if (stopping && decel && absv(speed_meas) >= prev_abs) begin
        if (stall_cnt == STALL_TICKS - 1)
          stall_zero_reg <= 1'b1;
        else
          stall_cnt <= stall_cnt + 32'h00000001;
      end else begin
        stall_cnt <= 32'h00000000;
      end
      if (run_state)
        stall_zero_reg <= 1'b0;
      if (tq_bypass && run_state) begin
        ramp_reg <= speed_ref;
        acc_reg  <= 18'sh00000;
      end else if (run_q && stopping && tq_bypass &&
                   smode == `RBT_STOP_RAMP) begin
        ramp_reg <= speed_meas;
        acc_reg  <= 18'sh00000;
      end else if (stall_zero_reg ||
                   (stopping && smode == `RBT_STOP_NORAMP)) begin
        ramp_reg <= 16'h0000;
        acc_reg  <= 18'sh00000;
      end else if (coast_c) begin
        ramp_reg <= speed_meas;
        acc_reg  <= 18'sh00000;
      end else if (!decel && was_reg_q) begin
        acc_reg   <= 18'sh00000;
        was_reg_q <= 1'b0;
      end else begin
        ramp_reg <= ramp_n[15:0];
        acc_reg  <= (s_act && !overshoot) ? acc_n : 18'sh00000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Torque reference sampling and torque mode selection

  reg  [15:0] tref_s;
  reg  [3:0]  samp_cnt;
  reg  signed [17:0] integ;
  wire fast_samp = ctrl_reg[`RBT_CTRL_SRC_AIN23] && closed &&
                   ctrl_reg[`RBT_CTRL_AIN_VZERO];
  wire [15:0] toff = ctrl_reg[`RBT_CTRL_OFF_EN] ? toff_reg : 16'h0000;
  wire [15:0] tres = sat16($signed({{4{tref_s[15]}}, tref_s}) +
                           $signed({{4{toff[15]}}, toff}));
  wire signed [15:0] slo = $signed(speed_loop_out);
  wire signed [15:0] str = $signed(tres);
  wire signed [15:0] lo = str[15] ? str : 16'sh0000;
  wire signed [15:0] hi = str[15] ? 16'sh0000 : str;
  wire signed [17:0] ierr = $signed({{2{tref_s[15]}}, tref_s})
                          - $signed({{2{current_fb[15]}}, current_fb});
  wire signed [17:0] integ_n = integ + (ierr >>> `RBT_PI_KI_SHIFT);
  wire signed [17:0] pi_sum = (ierr >>> `RBT_PI_KP_SHIFT) + integ;
  wire signed [17:0] fmax = $signed({2'b00, topf_reg});
  wire signed [17:0] pi_lim = (pi_sum > fmax) ? fmax :
                              (pi_sum < -fmax) ? -fmax : pi_sum;
  reg  [15:0] tsel;

  always @* begin
    case (tmode)
      3'h0: tsel = speed_loop_out;
      3'h1: tsel = tres;
      3'h2: tsel = (slo < lo) ? lo[15:0] :
                   (slo > hi) ? hi[15:0] : speed_loop_out;
      3'h3: tsel = tres;
      3'h4: tsel = sat16($signed({{4{slo[15]}}, slo}) +
                         $signed({{4{tres[15]}}, tres}));
      default: tsel = speed_loop_out;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tref_s   <= 16'h0000;
      samp_cnt <= 4'h0;
      integ    <= 18'sh00000;
    end else if (tick) begin
      samp_cnt <= (samp_cnt == `RBT_TREF_DIV - 1) ? 4'h0
                  : samp_cnt + 4'h1;
      if (fast_samp || samp_cnt == `RBT_TREF_DIV - 1)
        tref_s <= torque_ref_in;
      if (!closed && tmode == 3'h1)
        integ <= (integ_n > fmax) ? fmax :
                 (integ_n < -fmax) ? -fmax : integ_n;
      else
        integ <= 18'sh00000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_out       <= 16'h0000;
      torque_demand  <= 16'h0000;
      freq_ref_out   <= 16'h0000;
      reg_if_demand  <= 16'h0000;
      reg_iq_demand  <= 16'h0000;
      volt_scale     <= `RBT_VSCALE_NORM;
      coast_req      <= 1'b0;
      overspeed_trip <= 1'b0;
      ramp_bypass    <= 1'b0;
    end else begin
      // Trip set wins over a clear in the same cycle
      if (tick && tmode == 3'h1 && closed &&
          absv(speed_meas) > ovspd_reg)
        overspeed_trip <= 1'b1;
      else if (trip_clr)
        overspeed_trip <= 1'b0;
      if (tick) begin
        ramp_out      <= ramp_reg;
        torque_demand <= tsel;
        freq_ref_out  <= (!closed && tmode == 3'h1) ?
                         pi_lim[15:0] : ramp_reg;
        reg_if_demand <= (reg_act_reg && !closed) ? reg_cur
                         : 16'h0000;
        reg_iq_demand <= (reg_act_reg && closed) ? reg_cur
                         : 16'h0000;
        volt_scale    <= (decel && rmode == `RBT_RMODE_BOOST) ?
                         `RBT_VSCALE_BOOST : `RBT_VSCALE_NORM;
        coast_req     <= coast_c;
        ramp_bypass   <= tq_bypass && run_state;
      end
    end
  end

endmodule // rbt_ctrl
